// ### src/sst_pkg.sv
// Constants and types for the select-and-transfer sequencer.
// Assumes one 10 MHz clock, AXI4-Lite register access, simple SCSI pins.
//
// Functional notes
// - After command: data, status or message in
// - Bad disconnect message byte: terminated, byte kept
// - Bus release before disconnect message: terminated
// - Save-pointers message: end command, paused interrupt
// - Disconnect message: phase 42, keep running
// - Bus free: phase 43; interrupt 85 if enabled
// - Await reselection; wrong target terminates; else 44
// - Identify unit must match; match gives 45
// - Nonzero count: data phase; check direction
// - Move count bytes; zero count gives 46
// - Repeated disconnects cycle phases 41 to 45
// - Status phase: 47 start, 50 end, store byte
// - Command complete 00: phase 60, success interrupt
// - One more interrupt on bus free or REQ
// - Deferred success interrupt until bus released
// - Unexpected condition: terminate, stay connected if info
// - Phase codes 00, 10, 20, 30 as progress
// - Reissue while connected resumes at recorded phase
// - Resume releases ACK except from phase 46
// - Resume entry points for 10, 30, 44, 45
// - Identify out 1r000ttt then phase 20
package sst_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // Control / command
  localparam logic [7:0] OFS_PHASE  = 8'h04; // Phase progress
  localparam logic [7:0] OFS_STATUS = 8'h08; // Interrupt status
  localparam logic [7:0] OFS_UNIT   = 8'h0c; // Unit number / status byte
  localparam logic [7:0] OFS_DATA   = 8'h10; // Last message byte / data
  localparam logic [7:0] OFS_COUNT  = 8'h14; // Transfer count
  localparam logic [7:0] OFS_TGT    = 8'h18; // Target id

  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int CTL_GO    = 0; // Write 1: issue command (self clears)
  localparam int CTL_IDI   = 1; // intermediate_disconnect_irq_enable
  localparam int CTL_EDI   = 2; // completion_irq_defer_on_disconnect
  localparam int CTL_ADV   = 3; // Advanced features
  localparam int CTL_DPD   = 4; // data_phase_direction (1 = in)
  localparam int CTL_RSEL  = 5; // Reselect enable
  localparam int CTL_ATN   = 6; // Attention variant
  localparam int CTL_IACK  = 7; // Write 1: processor releases ACK

  // ------------------------------------------------------------------
  // Phase progress codes
  // ------------------------------------------------------------------
  localparam logic [7:0] PH_NONE = 8'h00;
  localparam logic [7:0] PH_SEL  = 8'h10;
  localparam logic [7:0] PH_IDO  = 8'h20;
  localparam logic [7:0] PH_CMD  = 8'h30;
  localparam logic [7:0] PH_SDP  = 8'h41;
  localparam logic [7:0] PH_DISC = 8'h42;
  localparam logic [7:0] PH_FREE = 8'h43;
  localparam logic [7:0] PH_RSEL = 8'h44;
  localparam logic [7:0] PH_IDI  = 8'h45;
  localparam logic [7:0] PH_DONE = 8'h46;
  localparam logic [7:0] PH_STS  = 8'h47;
  localparam logic [7:0] PH_STE  = 8'h50;
  localparam logic [7:0] PH_CC   = 8'h60;

  // ------------------------------------------------------------------
  // Message codes and interrupt codes
  // ------------------------------------------------------------------
  localparam logic [7:0] MSG_SDP  = 8'h02;
  localparam logic [7:0] MSG_DISC = 8'h04;
  localparam logic [7:0] MSG_CC   = 8'h00;
  localparam logic [4:0] MSG_IDIN = 5'h10; // Top bits 10000
  localparam logic [7:0] IRQ_OK   = 8'h16; // Successful completion
  localparam logic [7:0] IRQ_PAUS = 8'h21; // Paused / aborted
  localparam logic [7:0] IRQ_TERM = 8'h4b; // Terminated
  localparam logic [7:0] IRQ_IDIS = 8'h85; // Intermediate disconnect
  localparam logic [7:0] IRQ_NEXT = 8'h8e; // Bus free / new REQ later

  // ------------------------------------------------------------------
  // Bus phase encoding {msg, cd, io}
  // ------------------------------------------------------------------
  localparam logic [2:0] BP_DOUT = 3'h0;
  localparam logic [2:0] BP_DIN  = 3'h1;
  localparam logic [2:0] BP_COUT = 3'h2;
  localparam logic [2:0] BP_STAT = 3'h3;
  localparam logic [2:0] BP_MOUT = 3'h6;
  localparam logic [2:0] BP_MIN  = 3'h7;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_SEL, ST_INFO, ST_MOUT, ST_CMDB, ST_XFER, ST_WACK,
    ST_WFREE, ST_WRSEL, ST_POST, ST_WLINK
  } sst_state_e;
endpackage : sst_pkg

// ### src/sst_sequencer.sv
// Initiator sequencer for select-and-transfer after arbitration.
// Assumes a separate phy: sel_done/busy/req/phase come synchronous,
// each byte handshake (req_in with ack_out) completes in one exchange.
`timescale 1ns/1ps
module sst_sequencer
  import sst_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sel_done,
  input  wire logic        bus_busy,
  input  wire logic        scsi_req,
  input  wire logic [2:0]  scsi_phase,
  input  wire logic [7:0]  scsi_data_in,
  input  wire logic        resel_valid,
  input  wire logic [2:0]  resel_id,
  output logic             sel_start,
  output logic             scsi_ack,
  output logic             scsi_atn,
  output logic [7:0]       scsi_data_out,
  output logic             irq
);
  // ------------------------------------------------------------------
  // State record
  // ------------------------------------------------------------------
  typedef struct packed {
    sst_state_e  st;       // Sequencer state
    logic [7:0]  ctrl;     // Control bits
    logic [7:0]  phase;    // Phase progress
    logic [7:0]  istat;    // Last interrupt code
    logic [7:0]  unit;     // Unit number / status byte
    logic [7:0]  data;     // Last byte seen
    logic [15:0] count;    // Transfer count
    logic [2:0]  tgt;      // Target id
    logic [3:0]  cdb_left; // Command bytes still to send
    logic        conn;     // Connected as initiator
    logic        aw_ok;    // Write address held
    logic        w_ok;     // Write data held
    logic [7:0]  awa;      // Held write address
    logic [31:0] wd;       // Held write data
    logic        bv;       // Write response valid
    logic        rv;       // Read data valid
    logic [31:0] rd;       // Read data
    logic        sel;      // Selection request
    logic        ack;      // ACK pin
    logic        atn;      // ATN pin
    logic [7:0]  dout;     // Output byte
    logic        irq;      // Interrupt pending
  } sst_state_s;

  sst_state_s cur_ff;
  sst_state_s nxt_ff;

  // Read mux shared by the read channel
  function automatic logic [31:0] rd_mux(input sst_state_s s,
                                         input logic [7:0] a);
    case (a)
      OFS_CTRL:   rd_mux = {24'h0, s.ctrl};
      OFS_PHASE:  rd_mux = {24'h0, s.phase};
      OFS_STATUS: rd_mux = {23'h0, s.irq, s.istat};
      OFS_UNIT:   rd_mux = {24'h0, s.unit};
      OFS_DATA:   rd_mux = {24'h0, s.data};
      OFS_COUNT:  rd_mux = {16'h0, s.count};
      OFS_TGT:    rd_mux = {29'h0, s.tgt};
      default:    rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic do_wr;
    logic go;
    logic xfer;
    do_wr  = 1'b0;
    go     = 1'b0;
    xfer   = scsi_req && !cur_ff.ack; // REQ seen with ACK low
    nxt_ff = cur_ff;
    nxt_ff.sel = 1'b0;

    // AXI write: address and data taken in either order
    if (s_axi_awvalid && !cur_ff.aw_ok)
    begin
      nxt_ff.aw_ok = 1'b1;
      nxt_ff.awa   = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur_ff.w_ok)
    begin
      nxt_ff.w_ok = 1'b1;
      nxt_ff.wd   = s_axi_wdata;
    end
    if (cur_ff.aw_ok && cur_ff.w_ok && !cur_ff.bv)
    begin
      do_wr       = 1'b1;
      nxt_ff.bv   = 1'b1;
      nxt_ff.aw_ok = 1'b0;
      nxt_ff.w_ok = 1'b0;
    end
    if (cur_ff.bv && s_axi_bready)
      nxt_ff.bv = 1'b0;

    // Register writes; unmapped answers OKAY and stores nothing
    if (do_wr)
    begin
      case (cur_ff.awa)
        OFS_CTRL:
        begin
          nxt_ff.ctrl = {1'b0, cur_ff.wd[6:1], 1'b0};
          go          = cur_ff.wd[CTL_GO];
          if (cur_ff.wd[CTL_IACK])
            nxt_ff.ack = 1'b0;
          if (cur_ff.wd[CTL_GO] || cur_ff.wd[CTL_IACK])
            nxt_ff.irq = 1'b0; // Command write acknowledges interrupt
        end
        OFS_UNIT:  nxt_ff.unit  = cur_ff.wd[7:0];
        OFS_COUNT: nxt_ff.count = cur_ff.wd[15:0];
        OFS_TGT:   nxt_ff.tgt   = cur_ff.wd[2:0];
        default: ;
      endcase
    end

    // AXI read
    if (s_axi_arvalid && !cur_ff.rv)
    begin
      nxt_ff.rv = 1'b1;
      nxt_ff.rd = rd_mux(cur_ff, s_axi_araddr);
    end
    if (cur_ff.rv && s_axi_rready)
      nxt_ff.rv = 1'b0;

    case (cur_ff.st)
      ST_IDLE:
      begin
        if (go && cur_ff.conn)
        begin
          // Resume at recorded point
          nxt_ff.ctrl[CTL_ATN] = cur_ff.ctrl[CTL_ATN];
          if (cur_ff.phase != PH_DONE)
            nxt_ff.ack = 1'b0;
          case (cur_ff.phase)
            PH_SEL:  nxt_ff.st = ST_INFO;
            PH_CMD:  nxt_ff.st = ST_CMDB;
            PH_DISC: nxt_ff.st = ST_WFREE;
            PH_CC:   nxt_ff.st = ST_POST;
            default: nxt_ff.st = ST_INFO; // 20, 41, 44-46, 50
          endcase
          if (cur_ff.phase == PH_CMD)
            nxt_ff.cdb_left = 4'd6;
        end
        else if (go)
        begin
          nxt_ff.phase = PH_NONE;
          nxt_ff.sel   = 1'b1;
          nxt_ff.atn   = nxt_ff.ctrl[CTL_ATN];
          nxt_ff.st    = ST_SEL;
        end
      end
      ST_SEL:
      begin
        if (sel_done)
        begin
          nxt_ff.phase = PH_SEL;
          nxt_ff.conn  = 1'b1;
          nxt_ff.st    = ST_INFO;
        end
        else if (!bus_busy && !cur_ff.sel)
        begin
          nxt_ff.istat = IRQ_TERM; // Selection timed out
          nxt_ff.irq   = 1'b1;
          nxt_ff.st    = ST_IDLE;
        end
      end
      ST_INFO:
      begin
        // Decide what the requested phase means here
        if (!bus_busy)
        begin
          nxt_ff.istat = IRQ_TERM;
          nxt_ff.irq   = 1'b1;
          nxt_ff.conn  = 1'b0;
          nxt_ff.st    = ST_IDLE;
        end
        else if (scsi_req)
        begin
          nxt_ff.st = ST_IDLE;
          nxt_ff.istat = IRQ_TERM;
          nxt_ff.irq   = 1'b1;
          case (cur_ff.phase)
            PH_SEL, PH_IDO:
              if (cur_ff.phase == PH_SEL && cur_ff.ctrl[CTL_ATN])
              begin
                nxt_ff.irq = (scsi_phase != BP_MOUT);
                nxt_ff.st  = (scsi_phase == BP_MOUT) ? ST_MOUT : ST_IDLE;
              end
              else if (scsi_phase == BP_COUT)
              begin
                nxt_ff.irq = 1'b0;
                nxt_ff.phase = PH_CMD;
                nxt_ff.cdb_left = 4'd6;
                nxt_ff.st = ST_CMDB;
              end
            PH_RSEL, PH_STE:
              if (scsi_phase == BP_MIN)
              begin
                nxt_ff.irq = 1'b0;
                nxt_ff.st  = ST_XFER;
              end
            default:
              // After command, resume points 41, 45, 46
              if (scsi_phase == BP_MIN ||
                  scsi_phase == BP_STAT ||
                  ((scsi_phase == BP_DIN || scsi_phase == BP_DOUT) &&
                   cur_ff.count != 16'h0 && cur_ff.phase != PH_DONE &&
                   !(cur_ff.ctrl[CTL_ADV] &&
                     scsi_phase[0] != cur_ff.ctrl[CTL_DPD])))
              begin
                nxt_ff.irq = 1'b0;
                if (scsi_phase == BP_STAT)
                  nxt_ff.phase = PH_STS;
                nxt_ff.st = ST_XFER;
              end
          endcase
        end
      end
      ST_MOUT:
      if (xfer)
      begin
        // Identify byte 1r000ttt
        nxt_ff.dout  = {1'b1, cur_ff.ctrl[CTL_RSEL], 3'h0,
                        cur_ff.unit[2:0]};
        nxt_ff.ack   = 1'b1;
        nxt_ff.atn   = 1'b0;
        nxt_ff.phase = PH_IDO;
        nxt_ff.st    = ST_WACK;
      end
      ST_CMDB:
      if (xfer)
      begin
        nxt_ff.ack      = 1'b1;
        nxt_ff.cdb_left = cur_ff.cdb_left - 4'd1;
        nxt_ff.phase    = cur_ff.phase + 8'h01;
        nxt_ff.st       = ST_WACK;
      end
      ST_XFER:
      if (xfer)
      begin
        nxt_ff.data = scsi_data_in;
        nxt_ff.ack  = 1'b1;
        nxt_ff.st   = ST_WACK;
        case (scsi_phase)
          BP_DIN, BP_DOUT:
          begin
            nxt_ff.count = cur_ff.count - 16'h1;
            if (cur_ff.count == 16'h1)
              nxt_ff.phase = PH_DONE;
          end
          BP_STAT:
          begin
            nxt_ff.unit  = scsi_data_in;
            nxt_ff.phase = PH_STE;
          end
          default:
          begin
            // Message in byte: meaning set by progress point
            nxt_ff.st    = ST_IDLE;
            nxt_ff.irq   = 1'b1;
            nxt_ff.istat = IRQ_TERM;
            if (cur_ff.phase == PH_RSEL)
            begin
              if (scsi_data_in[7:3] == MSG_IDIN &&
                  scsi_data_in[2:0] == cur_ff.unit[2:0])
              begin
                nxt_ff.irq   = 1'b0;
                nxt_ff.phase = PH_IDI;
                nxt_ff.st    = ST_WACK;
              end
            end
            else if (cur_ff.phase == PH_STE)
            begin
              if (scsi_data_in == MSG_CC)
              begin
                nxt_ff.phase = PH_CC;
                nxt_ff.irq   = !cur_ff.ctrl[CTL_EDI];
                nxt_ff.istat = IRQ_OK;
                nxt_ff.st    = cur_ff.ctrl[CTL_EDI] ? ST_POST : ST_WLINK;
              end
            end
            else if (scsi_data_in == MSG_SDP)
            begin
              nxt_ff.phase = PH_SDP;
              nxt_ff.istat = IRQ_PAUS;
            end
            else if (scsi_data_in == MSG_DISC)
            begin
              nxt_ff.irq   = 1'b0;
              nxt_ff.phase = PH_DISC;
              nxt_ff.st    = ST_WFREE;
            end
          end
        endcase
      end
      ST_WACK:
      if (!scsi_req)
      begin
        // Target dropped REQ: release ACK and carry on
        nxt_ff.ack = 1'b0;
        nxt_ff.st  = (cur_ff.phase[7:4] == 4'h3 && cur_ff.cdb_left != 4'd0)
                     ? ST_CMDB : ST_INFO;
      end
      ST_WFREE:
      begin
        // ACK stays up until the target drops REQ
        if (!scsi_req)
          nxt_ff.ack = 1'b0;
        if (!bus_busy)
        begin
          nxt_ff.phase = PH_FREE;
          nxt_ff.conn  = 1'b0;
          if (cur_ff.ctrl[CTL_IDI])
          begin
            nxt_ff.istat = IRQ_IDIS;
            nxt_ff.irq   = 1'b1;
            nxt_ff.st    = ST_IDLE;
          end
          else
            nxt_ff.st = ST_WRSEL;
        end
      end
      ST_WRSEL:
      if (resel_valid)
      begin
        nxt_ff.conn = 1'b1;
        if (resel_id == cur_ff.tgt)
        begin
          nxt_ff.phase = PH_RSEL;
          nxt_ff.st    = ST_INFO;
        end
        else
        begin
          nxt_ff.istat = IRQ_TERM;
          nxt_ff.irq   = 1'b1;
          nxt_ff.st    = ST_IDLE;
        end
      end
      ST_POST:
      begin
        if (!scsi_req)
          nxt_ff.ack = 1'b0;
        if (!bus_busy)
        begin
          nxt_ff.conn  = 1'b0;
          nxt_ff.istat = IRQ_OK;
          nxt_ff.irq   = 1'b1;
          nxt_ff.st    = ST_IDLE;
        end
      end
      ST_WLINK:
      begin
        // Deferred second interrupt after processor takes the first
        if (!scsi_req)
          nxt_ff.ack = 1'b0;
        if (!cur_ff.irq && (!bus_busy || (scsi_req && !cur_ff.ack)))
        begin
          nxt_ff.conn  = bus_busy;
          nxt_ff.istat = IRQ_NEXT;
          nxt_ff.irq   = 1'b1;
          nxt_ff.st    = ST_IDLE;
        end
      end
      default: nxt_ff.st = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_ff;
  end

  // Outputs straight from the state flip-flops; bresp and rresp tied to OKAY
  assign s_axi_awready = !cur_ff.aw_ok;
  assign s_axi_wready  = !cur_ff.w_ok;
  assign s_axi_bvalid  = cur_ff.bv;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_arready = !cur_ff.rv;
  assign s_axi_rvalid  = cur_ff.rv;
  assign s_axi_rdata   = cur_ff.rd;
  assign s_axi_rresp   = 2'h0;
  assign sel_start     = cur_ff.sel;
  assign scsi_ack      = cur_ff.ack;
  assign scsi_atn      = cur_ff.atn;
  assign scsi_data_out = cur_ff.dout;
  assign irq           = cur_ff.irq;
endmodule : sst_sequencer

// ### dv/sst_sequencer_chk.sv
// Port checker for the sequencer: AXI answers, REQ/ACK, interrupt.
// Assumes it is bound into sst_sequencer; one clock, async resetn.
`timescale 1ns/1ps
module sst_sequencer_chk
  import sst_pkg::*;
(
  input logic        clk,
  input logic        resetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [7:0]  s_axi_awaddr,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        scsi_req,
  input logic        scsi_ack,
  input logic        irq
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_b_win;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_win: assert property (p_b_win)
    else $error("write answer late");
  property p_r_win;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_win: assert property (p_r_win)
    else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  // Addresses above the map (past 0x18) read as zero with an OKAY response
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
      |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_ack_cause;
    $rose(scsi_ack) |-> $past(scsi_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without req");
  property p_ack_hold;
    scsi_ack && scsi_req |=> scsi_ack;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack dropped before req");
  // A taken write may clear it two cycles later
  property p_irq_hold;
    irq && !$past(s_axi_awvalid && s_axi_awready ||
                  s_axi_wvalid && s_axi_wready) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt lost without a write");
  property p_irq_clr;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == OFS_CTRL &&
      s_axi_wvalid && s_axi_wready && (s_axi_wdata[0] || s_axi_wdata[7])
      |-> ##[1:3] !irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("interrupt not cleared");
endmodule : sst_sequencer_chk

bind sst_sequencer sst_sequencer_chk u_chk (.*);

// ### dv/sst_tgt.sv
// Behavioural SCSI target; the bench calls its tasks in sequence.
// Assumes one clock shared with the sequencer.
`timescale 1ns/1ps
module sst_tgt
  import sst_pkg::*;
(
  input  logic       clk,
  input  logic       sel_start,
  input  logic       scsi_ack,
  output logic       sel_done,
  output logic       bus_busy,
  output logic       scsi_req,
  output logic [2:0] scsi_phase,
  output logic [7:0] scsi_data_in,
  output logic       resel_valid,
  output logic [2:0] resel_id
);
  // Answer selection at once so a short start pulse is never missed
  always @(posedge clk)
  begin
    sel_done <= sel_start;
    if (sel_start) bus_busy <= 1'b1;
  end
  // Released bus: lines show a pattern, not a stale byte
  task automatic idle();
    bus_busy     <= 1'b0;
    scsi_req     <= 1'b0;
    scsi_phase   <= 3'h5;
    scsi_data_in <= 8'h5a;
    resel_valid  <= 1'b0;
    resel_id     <= 3'h0;
  endtask : idle
  // One byte; a held ACK must be released by the initiator first
  task automatic xfer(input logic [2:0] ph, input logic [7:0] b);
    int n;
    n = 0;
    while (scsi_ack && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    scsi_phase   <= ph;
    scsi_data_in <= b;
    scsi_req     <= 1'b1;
    n = 0;
    do @(posedge clk); while (!scsi_ack && ++n < 200);
    scsi_req     <= 1'b0;
    scsi_data_in <= ~b;
  endtask : xfer
  task automatic free();
    @(posedge clk);
    bus_busy   <= 1'b0;
    scsi_phase <= 3'h5;
    repeat (3) @(posedge clk);
  endtask : free
  task automatic resel(input logic [2:0] id);
    @(posedge clk);
    resel_valid <= 1'b1;
    resel_id    <= id;
    bus_busy    <= 1'b1;
    @(posedge clk);
    resel_valid <= 1'b0;
    resel_id    <= ~id;
  endtask : resel
  initial idle();
endmodule : sst_tgt

// ### dv/sst_sequencer_tb.sv
// Bench for the sequencer: AXI driver, target model, read monitor.
// Assumes a 10 MHz clock; expected reads queue up for the monitor.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
  num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module sst_sequencer_tb;
  import sst_pkg::*;
  typedef struct packed { logic [31:0] e; logic [31:0] m; } sst_note_s;
  logic        clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        ack_q = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, sel_done, bus_busy, scsi_req;
  logic        resel_valid, sel_start, scsi_ack, scsi_atn, irq;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, scsi_data_in;
  logic [7:0]  scsi_data_out, sb;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'd74, cfg;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [2:0]  scsi_phase, resel_id;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          num_errors = 0, checked = 0, cyc = 0;
  sst_note_s   notes[$];
  sst_sequencer u_dut (.*);
  sst_tgt       u_tgt (.*);
  always #50 clk = ~clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Empty queue: a note that can never match
  task automatic pop_cmp(input string nm, input logic [31:0] v);
    sst_note_s n;
    n = {32'hffff_ffff, 32'h0};
    if (notes.size() > 0) n = notes.pop_front();
    `CHK(nm, n.e, v & n.m)
  endtask : pop_cmp
  // ----------------------------------------------------------------
  // Monitor and hang limit (runs need far fewer cycles)
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    ack_q <= scsi_ack;
    if (s_axi_rvalid && s_axi_rready) pop_cmp("rdata", s_axi_rdata);
    if (scsi_ack && !ack_q && scsi_req && scsi_phase == BP_MOUT)
      pop_cmp("ident", {24'h0, scsi_data_out});
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hff);
    notes.push_back({e & m, m});
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wirq(input logic [7:0] code);
    while (!irq) @(posedge clk);
    rd(OFS_STATUS, {24'h0, code});
  endtask : wirq
  task automatic rst();
    @(posedge clk);
    resetn <= 1'b0;
    u_tgt.idle();
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
  endtask : rst
  // Fresh reset, selection, optional identify, six command bytes
  task automatic start(input logic [31:0] c, input logic [15:0] cnt);
    rst();
    cfg = c;
    wr(OFS_UNIT, 32'h3);
    wr(OFS_TGT, 32'h5);
    wr(OFS_COUNT, {16'h0, cnt});
    wr(OFS_CTRL, c | 32'h1);
    while (!bus_busy) @(posedge clk);
    `CHK("atn", c[CTL_ATN], scsi_atn)
    rd(OFS_PHASE, PH_SEL);
    if (c[CTL_ATN])
    begin
      notes.push_back({24'h0, 1'b1, c[CTL_RSEL], 6'h3, 32'hff});
      u_tgt.xfer(BP_MOUT, 8'h00);
      rd(OFS_PHASE, PH_IDO);
    end
    repeat (6) u_tgt.xfer(BP_COUT, 8'h00);
  endtask : start
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rst();
    rd(OFS_PHASE, PH_NONE);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    start(32'h60, 16'd2);
    repeat (2) u_tgt.xfer(BP_DIN, 8'(xs()));
    rd(OFS_PHASE, PH_DONE);
    sb = 8'(xs());
    u_tgt.xfer(BP_STAT, sb);
    rd(OFS_PHASE, PH_STE);
    u_tgt.xfer(BP_MIN, MSG_CC);
    wirq(IRQ_OK);
    rd(OFS_PHASE, PH_CC);
    rd(OFS_UNIT, {24'h0, sb});
    wr(OFS_CTRL, cfg | 32'h80);
    u_tgt.free();
    wirq(IRQ_NEXT);
    // Deferred success: nothing until the target leaves
    start(32'h4, 16'd0);
    u_tgt.xfer(BP_STAT, 8'h0);
    u_tgt.xfer(BP_MIN, MSG_CC);
    rd(OFS_PHASE, PH_CC);
    `CHK("irq", 1'b0, irq)
    wr(OFS_CTRL, cfg | 32'h80);
    u_tgt.free();
    wirq(IRQ_OK);
    // Bad message, save pointers, wrong data direction
    for (int k = 0; k < 3; k++)
    begin
      start(k == 2 ? 32'h18 : 32'h0, k == 2 ? 16'd1 : 16'd0);
      u_tgt.xfer(k == 2 ? BP_DOUT : BP_MIN, k == 0 ? 8'h07 : MSG_SDP);
      wirq(k == 1 ? IRQ_PAUS : IRQ_TERM);
      if (k == 0) rd(OFS_DATA, 32'h7);
      if (k == 1)
      begin
        wr(OFS_CTRL, 32'h1);
        u_tgt.xfer(BP_STAT, 8'h0);
        rd(OFS_PHASE, PH_STE);
      end
    end
    // Disconnect, then intermediate stop, stranger, own target
    for (int k = 0; k < 3; k++)
    begin
      start(k == 0 ? 32'h2 : 32'h0, 16'd1);
      u_tgt.xfer(BP_MIN, MSG_DISC);
      rd(OFS_PHASE, PH_DISC);
      wr(OFS_CTRL, cfg | 32'h80);
      u_tgt.free();
      if (k == 0) wirq(IRQ_IDIS);
      rd(OFS_PHASE, PH_FREE);
      if (k > 0) u_tgt.resel(k == 1 ? 3'h6 : 3'h5);
      if (k == 1) wirq(IRQ_TERM);
      if (k == 2)
      begin
        rd(OFS_PHASE, PH_RSEL);
        u_tgt.xfer(BP_MIN, {MSG_IDIN, 3'h3});
        rd(OFS_PHASE, PH_IDI);
        u_tgt.xfer(BP_DIN, 8'(xs()));
        rd(OFS_PHASE, PH_DONE);
      end
    end
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule : sst_sequencer_tb
